// *** core/stepper_motor_sequencer_regs.svh ***
// Register offsets, field positions, reset values and timing counts
// of the stepper motor sequencer. Definitions only.
`ifndef STEPPER_MOTOR_SEQUENCER_REGS_SVH
`define STEPPER_MOTOR_SEQUENCER_REGS_SVH

// Register offsets on the plain register port
`define OFS_STEP_CONTROL 32'h01ff8058
`define OFS_STEP_INTERVAL_TIMER 32'h01ff805a
`define OFS_PHASE_PATTERN 32'h01ff805c
`define OFS_STEP_CLOCK_DIVIDER 32'h01ff8853
`define OFS_PIN_FUNCTION_CONFIG 32'h01ff8060
`define OFS_DELAY_TIMER 32'h01ff8062
`define OFS_SEQ_STATUS 32'h01ff8064

// Step control fields
`define BIT_IRQ_CLEAR 0
`define BIT_STEP_ENABLE 1
`define BIT_DIRECTION 2
`define BIT_HALF_STEP 3
`define BIT_MOTOR_POWER 4

// Pin function config fields
`define BIT_SYNC_ENABLE 0
`define BIT_GENERAL_OUTPUT 1

// Field widths
`define DIVIDER_W 5
`define TIMER_W 14

// Reset values
`define RST_CONTROL 5'h00
`define RST_TIMER 14'h0000
`define RST_PATTERN 8'h00
`define RST_DIVIDER 5'h00

// Step tick clock is the core clock divided by this factor times (n+1)
`define TICK_BASE_DIV 8

`endif

// *** core/stepper_motor_sequencer_pkg.sv ***
// Types shared by the stepper motor sequencer.
// Assumes the constants header is included by the design file.
package stepper_motor_sequencer_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_SYNC,
        ST_DELAY,
        ST_STEP
    } seq_state_t;

    // Stored step control bits
    typedef struct packed {
        logic power;
        logic half_step;
        logic direction;
        logic enable;
    } step_ctrl_t;

    // Pin function and start synchronisation bits
    typedef struct packed {
        logic general_output;
        logic sync_enable;
    } pin_cfg_t;

endpackage

// *** core/stepper_motor_sequencer.sv ***
// Stepper motor sequencer: register port, step tick divider, delay and
// step timers, phase pattern advance and sticky step interrupt.
// Assumes one 100 MHz clock, a synchronous active-low reset and a
// register master that never issues read and write strobes together.
//
// Summary of operation
// - Full step uses low pattern nibble only
// - Half step holds current and next pattern
// - Tick equals clock over eight times (n+1)
// - Step interval is (n+1) tick periods
// - Control holds direction and enable, reset zero
// - Control holds power bit and interrupt clear
// - Step timer expiry pulses, interrupts and reloads
// - Each step pulse in motor mode advances the pattern once
// - Two reloadable timers: step and first delay
// - Scan start input, synchronisation selectable
// - Synchronised start waits for scan start pulse
// - Unsynchronised start loads delay timer at once
// - Delay timer expiry gives first step pulse
// - Delay timer runs once per enabling
// - Config bit selects motor lines or outputs
// - Pins always show pattern low nibble
// - Output mode writes appear on pins at once
// - Motor mode ignores pattern register writes
// - Pattern moves forward clockwise, backward otherwise
// - Disabling clears both timers and blocks steps
// - Power bit drives its output pin directly
`timescale 1ns/1ps
`include "stepper_motor_sequencer_regs.svh"

module stepper_motor_sequencer
    import stepper_motor_sequencer_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [31:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic scan_cycle_start_in,
    output logic [3:0] phase_lines_out,
    output logic general_output_mode_out,
    output logic motor_power_out,
    output logic step_pulse_out,
    output logic step_interrupt_out
);

    localparam int TICK_CNT_W = 8;

    step_ctrl_t ctrl_ff;
    pin_cfg_t cfg_ff;
    logic [`TIMER_W-1:0] step_reload_ff;
    logic [`TIMER_W-1:0] delay_reload_ff;
    logic [`DIVIDER_W-1:0] divider_ff;
    logic [7:0] pattern_ff;
    logic [`TIMER_W-1:0] step_cnt_ff;
    logic [`TIMER_W-1:0] delay_cnt_ff;
    logic [TICK_CNT_W-1:0] tick_cnt_ff;
    logic irq_ff;
    logic pulse_ff;
    logic enable_d_ff;
    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic [15:0] rdata_ff;
    seq_state_t state_ff;

    logic wr_ctrl;
    logic wr_pattern;
    logic tick;
    logic scan_pulse;
    logic start;
    logic step_now;
    logic [TICK_CNT_W-1:0] tick_reload;

    // Nibble rotations used by both excitation modes
    function automatic logic [3:0] rot_fwd(input logic [3:0] v);
        return {v[2:0], v[3]};
    endfunction

    function automatic logic [3:0] rot_back(input logic [3:0] v);
        return {v[0], v[3:1]};
    endfunction

    // Address decode for writes
    assign wr_ctrl = wr_in && (addr_in == `OFS_STEP_CONTROL);
    assign wr_pattern = wr_in && (addr_in == `OFS_PHASE_PATTERN);

    // Step control bits; bit 0 is a command and is not stored
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ctrl_ff <= step_ctrl_t'(4'(`RST_CONTROL >> 1));
        end else if (wr_ctrl) begin
            ctrl_ff.enable <= wdata_in[`BIT_STEP_ENABLE];
            ctrl_ff.direction <= wdata_in[`BIT_DIRECTION];
            ctrl_ff.half_step <= wdata_in[`BIT_HALF_STEP];
            ctrl_ff.power <= wdata_in[`BIT_MOTOR_POWER];
        end
    end

    // Remaining software registers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cfg_ff <= '0;
            step_reload_ff <= `RST_TIMER;
            delay_reload_ff <= `RST_TIMER;
            divider_ff <= `RST_DIVIDER;
        end else if (wr_in) begin
            case (addr_in)
                `OFS_PIN_FUNCTION_CONFIG: begin
                    cfg_ff.general_output <= wdata_in[`BIT_GENERAL_OUTPUT];
                    cfg_ff.sync_enable <= wdata_in[`BIT_SYNC_ENABLE];
                end
                `OFS_STEP_INTERVAL_TIMER: step_reload_ff <= wdata_in[`TIMER_W-1:0];
                `OFS_DELAY_TIMER: delay_reload_ff <= wdata_in[`TIMER_W-1:0];
                `OFS_STEP_CLOCK_DIVIDER: divider_ff <= wdata_in[`DIVIDER_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Registered read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rdata_ff <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                `OFS_STEP_CONTROL: rdata_ff <= {11'h000, ctrl_ff, irq_ff};
                `OFS_STEP_INTERVAL_TIMER: rdata_ff <= {2'h0, step_reload_ff};
                `OFS_PHASE_PATTERN: rdata_ff <= {8'h00, pattern_ff};
                `OFS_STEP_CLOCK_DIVIDER: rdata_ff <= {11'h000, divider_ff};
                `OFS_PIN_FUNCTION_CONFIG: rdata_ff <= {14'h0000, cfg_ff};
                `OFS_DELAY_TIMER: rdata_ff <= {2'h0, delay_reload_ff};
                `OFS_SEQ_STATUS: rdata_ff <= {12'h000, irq_ff, pulse_ff,
                    2'(state_ff)};
                default: rdata_ff <= 16'h0000;
            endcase
        end
    end

    // Scan start pin passes two flops; the edge is taken after the second
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= scan_cycle_start_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end
    assign scan_pulse = sync2_ff && !sync3_ff;

    // Tick divider: 8*(n+1) cycles; restarts while stepping is off so the
    // first interval after enabling is always a full tick
    assign tick_reload = TICK_CNT_W'(`TICK_BASE_DIV * (int'(divider_ff) + 1) - 1);
    assign tick = ctrl_ff.enable && (tick_cnt_ff == '0);
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tick_cnt_ff <= '0;
        end else if (!ctrl_ff.enable || tick) begin
            tick_cnt_ff <= tick_reload;
        end else begin
            tick_cnt_ff <= tick_cnt_ff - 1'b1;
        end
    end

    // Enable edge starts the one-shot delay sequence
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            enable_d_ff <= 1'b0;
        end else begin
            enable_d_ff <= ctrl_ff.enable;
        end
    end
    assign start = ctrl_ff.enable && !enable_d_ff;

    // A step is due when the running timer of the current phase expires
    assign step_now = tick && (((state_ff == ST_DELAY) && (delay_cnt_ff == '0))
        || ((state_ff == ST_STEP) && (step_cnt_ff == '0)));

    // Sequencer state and both timers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_IDLE;
            step_cnt_ff <= `RST_TIMER;
            delay_cnt_ff <= `RST_TIMER;
        end else if (!ctrl_ff.enable) begin
            state_ff <= ST_IDLE;
            step_cnt_ff <= '0;
            delay_cnt_ff <= '0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start && cfg_ff.sync_enable) begin
                        state_ff <= ST_WAIT_SYNC;
                    end else if (start) begin
                        delay_cnt_ff <= delay_reload_ff;
                        state_ff <= ST_DELAY;
                    end
                end
                ST_WAIT_SYNC: begin
                    if (scan_pulse) begin
                        delay_cnt_ff <= delay_reload_ff;
                        state_ff <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (step_now) begin
                        step_cnt_ff <= step_reload_ff;
                        state_ff <= ST_STEP;
                    end else if (tick) begin
                        delay_cnt_ff <= delay_cnt_ff - 1'b1;
                    end
                end
                ST_STEP: begin
                    if (step_now) begin
                        step_cnt_ff <= step_reload_ff;
                    end else if (tick) begin
                        step_cnt_ff <= step_cnt_ff - 1'b1;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Registered step pulse, one cycle wide
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= step_now;
        end
    end

    // Sticky interrupt; a new step beats a clear in the same cycle
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            irq_ff <= 1'b0;
        end else if (step_now) begin
            irq_ff <= 1'b1;
        end else if (wr_ctrl && wdata_in[`BIT_IRQ_CLEAR]) begin
            irq_ff <= 1'b0;
        end
    end

    // Phase pattern: written only as outputs, advanced only as motor lines.
    // Half step keeps the next pattern in the upper nibble, so two patterns
    // ahead is the lower nibble rotated by one phase.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pattern_ff <= `RST_PATTERN;
        end else if (cfg_ff.general_output) begin
            if (wr_pattern) begin
                pattern_ff <= wdata_in[7:0];
            end
        end else if (step_now) begin
            if (!ctrl_ff.half_step && !ctrl_ff.direction) begin
                pattern_ff[3:0] <= rot_fwd(pattern_ff[3:0]);
            end else if (!ctrl_ff.half_step) begin
                pattern_ff[3:0] <= rot_back(pattern_ff[3:0]);
            end else if (!ctrl_ff.direction) begin
                pattern_ff <= {rot_fwd(pattern_ff[3:0]), pattern_ff[7:4]};
            end else begin
                pattern_ff <= {pattern_ff[3:0], rot_back(pattern_ff[7:4])};
            end
        end
    end

    // Pins: low nibble in both functions, power bit passed straight out
    assign phase_lines_out = pattern_ff[3:0];
    assign general_output_mode_out = cfg_ff.general_output;
    assign motor_power_out = ctrl_ff.power;
    assign step_pulse_out = pulse_ff;
    assign step_interrupt_out = irq_ff;
    assign rdata_out = rdata_ff;

    // Checks on the design's own behaviour
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    a_disable_clears: assert property (!ctrl_ff.enable |=>
        step_cnt_ff == '0 && delay_cnt_ff == '0 && !step_now)
        else $error("timers not cleared while disabled");
    a_step_reload: assert property (state_ff == ST_STEP && step_now |=>
        step_cnt_ff == $past(step_reload_ff) && pulse_ff && irq_ff)
        else $error("step timer not reloaded on expiry");
    a_first_step: assert property (state_ff == ST_DELAY && step_now |=>
        state_ff == ST_STEP && pulse_ff)
        else $error("delay expiry did not give first step");
    a_delay_once: assert property (state_ff == ST_STEP |=>
        state_ff == ST_STEP || state_ff == ST_IDLE)
        else $error("delay timer reran during stepping");
    a_nosync_load: assert property (state_ff == ST_IDLE && start && !cfg_ff.sync_enable
        |=> state_ff == ST_DELAY && delay_cnt_ff == $past(delay_reload_ff))
        else $error("delay timer not loaded at enable");
    a_sync_wait: assert property (state_ff == ST_WAIT_SYNC && !scan_pulse
        && ctrl_ff.enable |=> state_ff == ST_WAIT_SYNC)
        else $error("left sync wait without scan start");
    a_irq_sticky: assert property (irq_ff && !(wr_ctrl && wdata_in[0])
        |=> irq_ff)
        else $error("interrupt dropped without clear");
    a_full_cw: assert property (step_now && !cfg_ff.general_output
        && !ctrl_ff.half_step && !ctrl_ff.direction
        |=> phase_lines_out == rot_fwd($past(pattern_ff[3:0])))
        else $error("clockwise full step wrong");
    a_gpo_write: assert property (wr_pattern && cfg_ff.general_output
        |=> phase_lines_out == $past(wdata_in[3:0]))
        else $error("output mode write not on pins");
    a_motor_ignore: assert property (wr_pattern && !cfg_ff.general_output
        && !step_now |=> $stable(pattern_ff))
        else $error("motor mode write changed pattern");
    a_tick_gap: assert property (tick |=> !tick [*7])
        else $error("step tick closer than eight cycles");

    // Remaining pattern moves and the clear path; a broken rotation in any
    // of the four modes would otherwise only show up on a real motor
    a_full_ccw: assert property (step_now && !cfg_ff.general_output
        && !ctrl_ff.half_step && ctrl_ff.direction
        |=> phase_lines_out == rot_back($past(pattern_ff[3:0])))
        else $error("counterclockwise full step wrong");
    a_half_cw: assert property (step_now && !cfg_ff.general_output
        && ctrl_ff.half_step && !ctrl_ff.direction
        |=> pattern_ff == {rot_fwd($past(pattern_ff[3:0])), $past(pattern_ff[7:4])})
        else $error("clockwise half step wrong");
    a_half_ccw: assert property (step_now && !cfg_ff.general_output
        && ctrl_ff.half_step && ctrl_ff.direction
        |=> pattern_ff == {$past(pattern_ff[3:0]), rot_back($past(pattern_ff[7:4]))})
        else $error("counterclockwise half step wrong");
    a_gpo_hold: assert property (cfg_ff.general_output && !wr_pattern
        |=> $stable(pattern_ff))
        else $error("output mode pins changed without write");
    a_irq_clear: assert property (wr_ctrl && wdata_in[`BIT_IRQ_CLEAR]
        && !step_now |=> !irq_ff)
        else $error("interrupt not cleared by write");
    a_pulse_single: assert property (pulse_ff |=> !pulse_ff)
        else $error("step pulse longer than one cycle");

    c_sync_start: cover property (state_ff == ST_WAIT_SYNC ##1 state_ff == ST_DELAY);
    c_two_steps: cover property (pulse_ff ##[1:300] pulse_ff);
    c_half_ccw: cover property (step_now && ctrl_ff.half_step && ctrl_ff.direction);
    c_clear_race: cover property (step_now && wr_ctrl && wdata_in[0]);

endmodule

// *** testbench/motor_driver_model.sv ***
// Behavioural model of the external motor driver on the phase lines.
// Assumes it sits on the sequencer's pattern pins and shares its clock.
`timescale 1ns/1ps

module motor_driver_model (
    input wire logic clock_in,
    input wire logic [3:0] phase_lines_in,
    output int moves_out
);
    logic [3:0] last_lines_ff = 4'h0;

    initial begin
        moves_out = 0;
    end

    // Each change of the winding pattern moves the rotor once
    always @(posedge clock_in) begin
        if (phase_lines_in !== last_lines_ff) begin
            moves_out <= moves_out + 1;
        end
        last_lines_ff <= phase_lines_in;
    end
endmodule

// *** testbench/stepper_motor_sequencer_tb_top.sv ***
// Self-checking bench for the stepper motor sequencer.
// Assumes the register header is on the include path.
`timescale 1ns/1ps
`include "stepper_motor_sequencer_regs.svh"

module stepper_motor_sequencer_tb_top;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [31:0] addr_in = 32'h0;
    logic [15:0] wdata_in = 16'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic scan_cycle_start_in = 1'b0;
    logic [15:0] rdata_out;
    logic [3:0] phase_lines_out;
    logic general_output_mode_out;
    logic motor_power_out;
    logic step_pulse_out;
    logic step_interrupt_out;
    int moves;
    int fails = 0;
    int checks_done = 0;
    int n;
    int m0;
    logic [15:0] v;

    stepper_motor_sequencer dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .scan_cycle_start_in(scan_cycle_start_in), .phase_lines_out(phase_lines_out),
        .general_output_mode_out(general_output_mode_out), .motor_power_out(motor_power_out),
        .step_pulse_out(step_pulse_out), .step_interrupt_out(step_interrupt_out));

    motor_driver_model driver (.clock_in(clock_in), .phase_lines_in(phase_lines_out),
        .moves_out(moves));

    always #5 clock_in = ~clock_in;

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bus tasks are entered just after a rising edge
    task wr(input logic [31:0] a, input logic [15:0] d);
        // A write ending in this step lets one edge pass, so the strobe
        // is never assigned twice in one step
        if (wr_in === 1'b1) begin
            @(posedge clock_in);
        end
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    task rd(input logic [31:0] a, output logic [15:0] d);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(posedge clock_in);
        d = rdata_out;
    endtask

    // Edges until a step pulse is sampled, capped so a dead sequencer cannot hang
    task wait_step(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge clock_in);
            cnt++;
        end while (step_pulse_out !== 1'b1 && cnt < lim);
    endtask

    task t_reset;
        chk("pins", 16'h0000, {9'h0, phase_lines_out, motor_power_out, step_interrupt_out,
            general_output_mode_out});
        rd(`OFS_STEP_CONTROL, v);
        chk("control", 16'h0000, v);
        rd(`OFS_PHASE_PATTERN, v);
        chk("pattern", 16'h0000, v);
        rd(32'h01ff8066, v);
        chk("unmapped", 16'h0000, v);
        wr(`OFS_STEP_INTERVAL_TIMER, 16'hffff);
        rd(`OFS_STEP_INTERVAL_TIMER, v);
        chk("timer width", 16'h3fff, v);
        wr(`OFS_STEP_CLOCK_DIVIDER, 16'hffff);
        rd(`OFS_STEP_CLOCK_DIVIDER, v);
        chk("divider width", 16'h001f, v);
    endtask

    task t_gpo;
        wr(`OFS_PHASE_PATTERN, 16'h0011);
        rd(`OFS_PHASE_PATTERN, v);
        chk("refused pattern", 16'h0000, v);
        wr(`OFS_PIN_FUNCTION_CONFIG, 16'h0002);
        wr(`OFS_PHASE_PATTERN, 16'h0023);
        @(posedge clock_in);
        chk("output pins", 16'h0003, {12'h0, phase_lines_out});
        chk("output mode", 16'h0001, {15'h0, general_output_mode_out});
        rd(`OFS_PHASE_PATTERN, v);
        chk("pattern", 16'h0023, v);
        wr(`OFS_PIN_FUNCTION_CONFIG, 16'h0000);
    endtask

    // Divider 1 gives 16 cycles a tick; reload taken only at expiry
    task t_full;
        wr(`OFS_STEP_CLOCK_DIVIDER, 16'h0001);
        wr(`OFS_DELAY_TIMER, 16'h0001);
        wr(`OFS_STEP_INTERVAL_TIMER, 16'h0002);
        wr(`OFS_STEP_CONTROL, 16'h0002);
        wait_step(200, n);
        chk("first delay", 16'h0021, n[15:0]);
        chk("cw lines", 16'h0006, {12'h0, phase_lines_out});
        chk("irq set", 16'h0001, {15'h0, step_interrupt_out});
        wr(`OFS_STEP_INTERVAL_TIMER, 16'h0000);
        wait_step(200, n);
        chk("interval", 16'h002f, n[15:0]);
        chk("cw lines", 16'h000c, {12'h0, phase_lines_out});
        wait_step(200, n);
        chk("reloaded", 16'h0010, n[15:0]);
        repeat (5) @(posedge clock_in);
        chk("irq held", 16'h0001, {15'h0, step_interrupt_out});
        wr(`OFS_STEP_CONTROL, 16'h0003);
        @(posedge clock_in);
        chk("irq clear", 16'h0000, {15'h0, step_interrupt_out});
        m0 = moves;
        wr(`OFS_STEP_CONTROL, 16'h0006);
        wait_step(200, n);
        chk("ccw lines", 16'h000c, {12'h0, phase_lines_out});
        @(posedge clock_in);
        chk("driver moves", 16'h0001, 16'(moves - m0));
        wr(`OFS_STEP_CONTROL, 16'h0000);
        wait_step(300, n);
        chk("stopped", 16'h012c, n[15:0]);
    endtask

    task t_half;
        wr(`OFS_PIN_FUNCTION_CONFIG, 16'h0002);
        wr(`OFS_PHASE_PATTERN, 16'h0023);
        wr(`OFS_PIN_FUNCTION_CONFIG, 16'h0000);
        wr(`OFS_STEP_CONTROL, 16'h000a);
        wait_step(200, n);
        chk("half lines", 16'h0002, {12'h0, phase_lines_out});
        rd(`OFS_PHASE_PATTERN, v);
        chk("half cw", 16'h0062, v);
        wr(`OFS_STEP_CONTROL, 16'h000e);
        wait_step(200, n);
        rd(`OFS_PHASE_PATTERN, v);
        chk("half ccw", 16'h0023, v);
        wr(`OFS_STEP_CONTROL, 16'h0000);
    endtask

    // Scan pulse gates the delay; later steps use the step reload only
    task t_sync;
        wr(`OFS_PIN_FUNCTION_CONFIG, 16'h0001);
        wr(`OFS_DELAY_TIMER, 16'h0003);
        rd(`OFS_DELAY_TIMER, v);
        chk("delay reg", 16'h0003, v);
        wr(`OFS_STEP_CONTROL, 16'h0002);
        wait_step(100, n);
        chk("waits sync", 16'h0064, n[15:0]);
        scan_cycle_start_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        scan_cycle_start_in <= 1'b0;
        wait_step(300, n);
        chk("sync lines", 16'h0006, {12'h0, phase_lines_out});
        wait_step(200, n);
        chk("no redelay", 16'h0010, n[15:0]);
        // Power on, stepping off and the pending interrupt cleared together
        wr(`OFS_STEP_CONTROL, 16'h0011);
        @(posedge clock_in);
        chk("power pin", 16'h0001, {15'h0, motor_power_out});
        rd(`OFS_STEP_CONTROL, v);
        chk("control", 16'h0010, v);
    endtask

    // Reset held low for three edges, then released on an edge
    initial begin
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        t_reset;
        t_gpo;
        t_full;
        t_half;
        t_sync;
        complete_run;
    end

    // Whole run needs under two thousand cycles
    initial begin
        repeat (5000) @(posedge clock_in);
        fails++;
        complete_run;
    end
endmodule
